// ===== common/dgc_pkg.sv
package dgc_pkg;

   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam int AXI_AW = 8;
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_LAST_ADDR = 8'h08;
   localparam logic [7:0] OFS_CRC_CTRL = 8'h0C;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTL_ON_BIT = 15;
   localparam int CTL_SUSPEND_BIT = 12;
   localparam int CTL_BUSY_BIT = 11;
   localparam int STS_DIR_BIT = 3;
   localparam int CRC_CRC_BYTE_ORDER_LSB = 28;
   localparam int CRC_WBO_BIT = 27;
   localparam int CRC_CRC_BIT_ORDER_BIT = 24;
   localparam int CRC_POLYNOMIAL_LENGTH_LSB = 8;
   localparam int CRC_EN_BIT = 7;
   localparam int CRC_APP_BIT = 6;
   localparam int CRC_TYP_BIT = 5;
   localparam int CRC_CH_LSB = 0;

   // ----------------------------------------
   // writable masks and reset values
   // ----------------------------------------
   localparam logic [31:0] CTL_WR_MASK = 32'h0000_9000;
   localparam logic [31:0] CRC_WR_MASK = 32'h3900_1FE7;
   localparam logic [31:0] CTL_RESET = 32'h0000_0000;
   localparam logic [31:0] CRC_RESET = 32'h0000_0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // ----------------------------------------
   // bus answers
   // ----------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // byte order selection codes
   typedef enum logic [1:0] {
      ORD_NONE = 2'h0,
      ORD_WORD_REV = 2'h1,
      ORD_HALF_SWAP = 2'h2,
      ORD_BYTE_IN_HALF = 2'h3
   } dgc_order_t;

   // access sequencer states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_XFER = 2'h2
   } dgc_state_t;

   // merge a strobed write into a register, keeping only writable bits
   function automatic logic [31:0] dgc_apply_strb(input logic [31:0] old_val, input logic [31:0] wdata,
                                                  input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] merged;
      merged = old_val;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            merged[i*8 +: 8] = wdata[i*8 +: 8];
         end
      end
      return merged & mask;
   endfunction : dgc_apply_strb

endpackage : dgc_pkg

// ===== core/dgc_byte_order.sv
`timescale 1ns/1ps
module dgc_byte_order
   import dgc_pkg::*;
(
   input wire dgc_pkg::dgc_order_t order,
   input wire logic [31:0] din,
   output logic [31:0] dout
);
   import dgc_pkg::*;

   // ----------------------------------------
   // byte reordering ahead of the crc
   // ----------------------------------------
   // byte order select
   always_comb begin
      unique case (order)
         // source order untouched
         ORD_NONE: dout = din;
         // all four bytes reversed
         ORD_WORD_REV: dout = {din[7:0], din[15:8], din[23:16], din[31:24]};
         // half-words exchanged, bytes kept
         ORD_HALF_SWAP: dout = {din[15:0], din[31:16]};
         // bytes exchanged inside each half-word
         ORD_BYTE_IN_HALF: dout = {din[23:16], din[31:24], din[7:0], din[15:8]};
      endcase
   end

endmodule : dgc_byte_order

// ===== core/dgc_axil_slave.sv
`timescale 1ns/1ps
module dgc_axil_slave
   import dgc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [dgc_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_pulse,
   output logic [dgc_pkg::AXI_AW-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ok,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   import dgc_pkg::*;

   // all handshake state of the slave
   typedef struct packed {
      logic aw_rdy;
      logic [AXI_AW-1:0] aw_addr;
      logic w_rdy;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic wr_pulse;
      logic ar_rdy;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } dgc_axil_t;

   dgc_axil_t s_reg;
   dgc_axil_t s_next;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.wr_pulse = 1'b0;
      // address and data are taken in either order
      if (s_axi_awvalid && s_reg.aw_rdy) begin
         s_next.aw_rdy = 1'b0;
         s_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_reg.w_rdy) begin
         s_next.w_rdy = 1'b0;
         s_next.w_data = s_axi_wdata;
         s_next.w_strb = s_axi_wstrb;
      end
      // both held: commit the write and answer
      if (!s_reg.aw_rdy && !s_reg.w_rdy && !s_reg.bvalid) begin
         s_next.wr_pulse = 1'b1;
         s_next.bvalid = 1'b1;
         s_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      // response taken: reopen both channels
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
         s_next.aw_rdy = 1'b1;
         s_next.w_rdy = 1'b1;
      end
      // read: data sampled at the address handshake
      if (s_axi_arvalid && s_reg.ar_rdy) begin
         s_next.ar_rdy = 1'b0;
         s_next.rvalid = 1'b1;
         s_next.rdata = rd_ok ? rd_data : WORD_ZERO;
         s_next.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
         s_next.ar_rdy = 1'b1;
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         s_reg <= '0;
         s_reg.aw_rdy <= 1'b1;
         s_reg.w_rdy <= 1'b1;
         s_reg.ar_rdy <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state flops
   assign s_axi_awready = s_reg.aw_rdy;
   assign s_axi_wready = s_reg.w_rdy;
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_bresp = s_reg.bresp;
   assign s_axi_arready = s_reg.ar_rdy;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_rdata = s_reg.rdata;
   assign s_axi_rresp = s_reg.rresp;
   assign wr_pulse = s_reg.wr_pulse;
   assign wr_addr = s_reg.aw_addr;
   assign wr_data = s_reg.w_data;
   assign wr_strb = s_reg.w_strb;

endmodule : dgc_axil_slave

// ===== core/dgc_top.sv
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps

module dgc_top
   import dgc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [dgc_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [dgc_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic acc_req,
   input wire logic [2:0] acc_channel,
   input wire logic acc_is_read,
   input wire logic [31:0] acc_addr,
   input wire logic [31:0] acc_src_data,
   output logic acc_grant,
   output logic acc_refused,
   output logic bus_valid,
   output logic bus_read,
   output logic [31:0] bus_addr,
   output logic [31:0] bus_wdata,
   output logic crc_feed_valid,
   output logic [31:0] crc_feed_data,
   output logic module_enable,
   output logic module_active_flag,
   output logic crc_route_enable,
   output logic crc_append_mode,
   output logic crc_type_select,
   output logic crc_bit_order,
   output logic [4:0] polynomial_length,
   output logic [2:0] crc_channel_select
);
   import dgc_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   // every flop of this module in one record; the bus slave keeps its handshake flops in its own
   typedef struct packed {
      logic [31:0] ctl_word;
      logic [31:0] crc_word;
      logic busy;
      logic last_dir;
      logic [2:0] last_ch;
      logic [31:0] last_addr;
      dgc_state_t state;
      logic grant;
      logic refused;
      logic bus_valid;
      logic bus_read;
      logic [31:0] bus_addr;
      logic [31:0] bus_wdata;
      logic feed_valid;
      logic [31:0] feed_data;
   } dgc_top_t;

   dgc_top_t t_reg;
   dgc_top_t t_next;

   // register bus side
   logic wr_pulse;
   logic [AXI_AW-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_ok;
   logic [31:0] rd_data;
   logic rd_ok;
   // crc control value being written
   logic [31:0] crc_wr_val;
   // source data after byte reordering
   logic [31:0] reordered;
   // decoded control fields
   logic on_bit;
   logic suspend_bit;
   logic wbo_bit;
   logic unaligned;

   // ----------------------------------------
   // register bus slave
   // ----------------------------------------
   dgc_axil_slave u_slave (
      .mclk(mclk),
      .reset_n(reset_n),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_pulse(wr_pulse),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(wr_ok),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // ----------------------------------------
   // byte reorder unit
   // ----------------------------------------
   dgc_byte_order u_order (
      .order(dgc_order_t'(t_reg.crc_word[CRC_CRC_BYTE_ORDER_LSB +: 2])),
      .din(acc_src_data),
      .dout(reordered)
   );

   // field decode
   assign on_bit = t_reg.ctl_word[CTL_ON_BIT];
   assign suspend_bit = t_reg.ctl_word[CTL_SUSPEND_BIT];
   assign wbo_bit = t_reg.crc_word[CRC_WBO_BIT];
   assign unaligned = (acc_addr[1:0] != 2'h0);

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   // writes are answered OKAY at all four mapped registers; only control and crc control store them
   always_comb begin
      wr_ok = (wr_addr == OFS_CONTROL) || (wr_addr == OFS_CRC_CTRL) ||
              (wr_addr == OFS_STATUS) || (wr_addr == OFS_LAST_ADDR);
   end

   // read mux; unimplemented bits come back as zero
   // reserved bits zero
   always_comb begin
      rd_ok = 1'b1;
      rd_data = WORD_ZERO;
      if (s_axi_araddr == OFS_CONTROL) begin
         rd_data = t_reg.ctl_word;
         rd_data[CTL_BUSY_BIT] = t_reg.busy;
      end else if (s_axi_araddr == OFS_STATUS) begin
         rd_data[STS_DIR_BIT] = t_reg.last_dir;
         rd_data[2:0] = t_reg.last_ch;
      end else if (s_axi_araddr == OFS_LAST_ADDR) begin
         rd_data = t_reg.last_addr;
      end else if (s_axi_araddr == OFS_CRC_CTRL) begin
         rd_data = t_reg.crc_word;
      end else begin
         // unmapped address
         rd_ok = 1'b0;
      end
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      t_next = t_reg;
      t_next.grant = 1'b0;
      t_next.refused = 1'b0;
      t_next.bus_valid = 1'b0;
      t_next.feed_valid = 1'b0;
      crc_wr_val = dgc_apply_strb(t_reg.crc_word, wr_data, wr_strb, CRC_WR_MASK);
      if (crc_wr_val[CRC_WBO_BIT]) begin
         crc_wr_val[CRC_APP_BIT] = 1'b0;
      end
      // software writes; read-only registers ignore them
      // masked register writes
      if (wr_pulse && (wr_addr == OFS_CONTROL)) begin
         t_next.ctl_word = dgc_apply_strb(t_reg.ctl_word, wr_data, wr_strb, CTL_WR_MASK);
      end
      if (wr_pulse && (wr_addr == OFS_CRC_CTRL)) begin
         t_next.crc_word = crc_wr_val;
      end
      // access sequencer
      unique case (t_reg.state)
         ST_IDLE: begin
            if (on_bit && !suspend_bit && acc_req) begin
               if (wbo_bit && unaligned) begin
                  t_next.refused = 1'b1;
               end else begin
                  t_next.state = ST_XFER;
                  t_next.grant = 1'b1;
                  t_next.bus_valid = 1'b1;
                  t_next.bus_read = acc_is_read;
                  t_next.bus_addr = acc_addr;
                  t_next.bus_wdata = wbo_bit ? reordered : acc_src_data;
                  t_next.feed_valid = t_reg.crc_word[CRC_EN_BIT] &&
                                      (acc_channel == t_reg.crc_word[CRC_CH_LSB +: 3]);
                  t_next.feed_data = reordered;
                  t_next.last_dir = acc_is_read;
                  t_next.last_ch = acc_channel;
                  t_next.last_addr = acc_addr;
               end
            end
         end
         ST_XFER: begin
            // access always runs to its end
            t_next.state = ST_IDLE;
         end
      endcase
      // busy while on or moving data
      t_next.busy = t_next.ctl_word[CTL_ON_BIT] || (t_next.state == ST_XFER);
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         t_reg <= '0;
         t_reg.ctl_word <= CTL_RESET;
         t_reg.crc_word <= CRC_RESET;
         t_reg.state <= ST_IDLE;
      end else begin
         t_reg <= t_next;
      end
   end

   // outputs straight from flops
   assign acc_grant = t_reg.grant;
   assign acc_refused = t_reg.refused;
   assign bus_valid = t_reg.bus_valid;
   assign bus_read = t_reg.bus_read;
   assign bus_addr = t_reg.bus_addr;
   assign bus_wdata = t_reg.bus_wdata;
   assign crc_feed_valid = t_reg.feed_valid;
   assign crc_feed_data = t_reg.feed_data;
   assign module_enable = on_bit;
   assign module_active_flag = t_reg.busy;
   assign crc_route_enable = t_reg.crc_word[CRC_EN_BIT];
   assign crc_append_mode = t_reg.crc_word[CRC_APP_BIT];
   assign crc_type_select = t_reg.crc_word[CRC_TYP_BIT];
   assign crc_bit_order = t_reg.crc_word[CRC_CRC_BIT_ORDER_BIT];
   assign polynomial_length = t_reg.crc_word[CRC_POLYNOMIAL_LENGTH_LSB +: 5];
   assign crc_channel_select = t_reg.crc_word[CRC_CH_LSB +: 3];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking dgc_cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   a_grant_needs_on: assert property (acc_grant |-> $past(on_bit) && $past(!suspend_bit))
      else $error("access started while off or suspended");
   a_suspend_holds_off: assert property (suspend_bit && (t_reg.state == ST_IDLE) |=> !bus_valid)
      else $error("access started during suspend");
   a_busy_follows: assert property (!on_bit && (t_reg.state == ST_IDLE) |-> !module_active_flag)
      else $error("busy set while off and idle");
   a_dir_capture: assert property (acc_grant |-> t_reg.last_dir == $past(acc_is_read))
      else $error("direction flag not captured");
   a_chan_capture: assert property (acc_grant |-> t_reg.last_ch == $past(acc_channel))
      else $error("channel not captured");
   a_addr_capture: assert property (bus_valid |-> t_reg.last_addr == bus_addr && acc_grant)
      else $error("address status out of step");
   a_dest_plain: assert property (bus_valid && !$past(wbo_bit) |-> bus_wdata == $past(acc_src_data))
      else $error("destination data altered");
   a_append_blocked: assert property (wbo_bit |-> !crc_append_mode)
      else $error("append set with write-order");
   a_crc_routing: assert property (crc_feed_valid |-> $past(crc_route_enable) && bus_valid)
      else $error("crc fed while disabled");
   a_one_cycle_xfer: assert property (bus_valid |=> !bus_valid)
      else $error("access longer than one cycle");
   a_ctl_reserved: assert property ((t_reg.ctl_word & ~CTL_WR_MASK) == WORD_ZERO)
      else $error("reserved control bit set");

endmodule : dgc_top

// ===== verification/dgc_req_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// channel engine stand-in on the access port
// ----------------------------------------
module dgc_req_model (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic [2:0] cmd_channel,
   input wire logic cmd_read,
   input wire logic [31:0] cmd_addr,
   input wire logic [31:0] cmd_data,
   input wire logic acc_grant,
   input wire logic acc_refused,
   input wire logic crc_feed_valid,
   output logic acc_req,
   output logic [2:0] acc_channel,
   output logic acc_is_read,
   output logic [31:0] acc_addr,
   output logic [31:0] acc_src_data,
   output logic done,
   output logic was_refused,
   output logic saw_feed
);
   // request holds until granted or refused; afterwards the payload is inverted so stale values never pass
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         acc_req <= 1'b0;
         acc_channel <= 3'h0;
         acc_is_read <= 1'b0;
         acc_addr <= 32'h0000_0000;
         acc_src_data <= 32'h0000_0000;
         done <= 1'b0;
         was_refused <= 1'b0;
         saw_feed <= 1'b0;
      end else if (acc_req && (acc_grant || acc_refused)) begin
         // answer seen: drop the request on this edge
         acc_req <= 1'b0;
         acc_addr <= ~acc_addr;
         acc_src_data <= ~acc_src_data;
         done <= 1'b1;
         was_refused <= acc_refused;
         saw_feed <= crc_feed_valid;
      end else if (start) begin
         // new command from the bench
         acc_req <= 1'b1;
         acc_channel <= cmd_channel;
         acc_is_read <= cmd_read;
         acc_addr <= cmd_addr;
         acc_src_data <= cmd_data;
         done <= 1'b0;
      end
   end
endmodule : dgc_req_model

// ===== verification/dma_global_ctrl_crc_order_tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// bench top: axi master, access stimulus, checks
// ----------------------------------------
module dma_global_ctrl_crc_order_tb_top;
   import dgc_pkg::*;
   logic mclk, reset_n;
   logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, bus_addr, bus_wdata, crc_feed_data, acc_addr, acc_src_data;
   logic [31:0] cmd_addr, cmd_data, v;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic acc_req, acc_is_read, acc_grant, acc_refused, bus_valid, bus_read, crc_feed_valid;
   logic module_enable, module_active_flag, crc_route_enable, crc_append_mode, crc_type_select, crc_bit_order;
   logic [4:0] polynomial_length;
   logic [2:0] crc_channel_select, acc_channel, cmd_channel;
   logic start, cmd_read, done, was_refused, saw_feed;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;

   // design and far-side model
   dgc_top dgc_top_i (.mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .acc_req, .acc_channel,
      .acc_is_read, .acc_addr, .acc_src_data, .acc_grant, .acc_refused, .bus_valid, .bus_read, .bus_addr,
      .bus_wdata, .crc_feed_valid, .crc_feed_data, .module_enable, .module_active_flag, .crc_route_enable,
      .crc_append_mode, .crc_type_select, .crc_bit_order, .polynomial_length, .crc_channel_select);
   dgc_req_model dgc_req_model_i (.mclk, .reset_n, .start, .cmd_channel, .cmd_read, .cmd_addr, .cmd_data,
      .acc_grant, .acc_refused, .crc_feed_valid, .acc_req, .acc_channel, .acc_is_read, .acc_addr,
      .acc_src_data, .done, .was_refused, .saw_feed);

   // 40 mhz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // hang guard, far above the expected run length
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         give_verdict();
      end
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : give_verdict

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // axi-lite write; response code left in r
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge mclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask : wr

   // axi-lite read; data left in v, response in r
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge mclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            v = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask : rd

   // hand one access to the model; wait_done waits for its answer
   task automatic issue(input logic [2:0] ch, input logic rdn, input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk);
      start <= 1'b1;
      cmd_channel <= ch;
      cmd_read <= rdn;
      cmd_addr <= a;
      cmd_data <= d;
      @(posedge mclk);
      start <= 1'b0;
      @(posedge mclk);
   endtask : issue

   task automatic wait_done();
      while (!done)
         @(posedge mclk);
   endtask : wait_done

   // expected byte order per selection code
   function automatic logic [31:0] reord(input logic [1:0] c, input logic [31:0] d);
      case (c)
         2'h1: return {d[7:0], d[15:8], d[23:16], d[31:24]};
         2'h2: return {d[15:0], d[31:16]};
         2'h3: return {d[23:16], d[31:24], d[7:0], d[15:8]};
         default: return d;
      endcase
   endfunction : reord

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_reset();
      rd(OFS_CONTROL);
      check(v, 32'h0000_0000);
      rd(OFS_STATUS);
      check(v, 32'h0000_0000);
      rd(OFS_LAST_ADDR);
      check(v, 32'h0000_0000);
      rd(OFS_CRC_CTRL);
      check(v, 32'h0000_0000);
      // unmapped place refuses both ways
      rd(8'h10);
      check(32'(r), 32'(RESP_SLVERR));
      check(v, 32'h0000_0000);
      wr(8'h10, 32'hFFFF_FFFF, 4'hF);
      check(32'(r), 32'(RESP_SLVERR));
      $display("test_reset done");
   endtask : test_reset

   task automatic test_regs();
      wr(OFS_CONTROL, 32'hFFFF_FFFF, 4'hF);
      check(32'(r), 32'(RESP_OKAY));
      rd(OFS_CONTROL);
      check(v, 32'h0000_9800);
      check(32'(module_enable), 32'h0000_0001);
      // lane strobe keeps upper bytes
      wr(OFS_CONTROL, 32'h0000_0000, 4'h1);
      rd(OFS_CONTROL);
      check(v, 32'h0000_9800);
      // append cannot be stored alongside write order
      wr(OFS_CRC_CTRL, 32'hFFFF_FFFF, 4'hF);
      rd(OFS_CRC_CTRL);
      check(v, 32'h3900_1FA7);
      check(32'({crc_route_enable, crc_append_mode, crc_type_select, crc_bit_order}), 32'h0000_000B);
      check(32'({polynomial_length, crc_channel_select}), 32'h0000_00FF);
      wr(OFS_CRC_CTRL, 32'h0000_0040, 4'hF);
      @(posedge mclk);
      check(32'(crc_append_mode), 32'h0000_0001);
      // read-only places ignore writes
      wr(OFS_STATUS, 32'hFFFF_FFFF, 4'hF);
      rd(OFS_STATUS);
      check(v, 32'h0000_0000);
      wr(OFS_LAST_ADDR, 32'hFFFF_FFFF, 4'hF);
      rd(OFS_LAST_ADDR);
      check(v, 32'h0000_0000);
      $display("test_regs done");
   endtask : test_regs

   task automatic test_access();
      logic [31:0] d;
      d = 32'h1122_3344;
      wr(OFS_CONTROL, 32'h0000_8000, 4'hF);
      for (int c = 0; c < 4; c++) begin
         wr(OFS_CRC_CTRL, 32'h0800_0085 | (32'(c) << 28), 4'hF);
         issue(3'h5, 1'b0, 32'h1000_0000 + 32'(4 * c), d);
         wait_done();
         check(crc_feed_data, reord(2'(c), d));
         check(bus_wdata, reord(2'(c), d));
         check(32'(saw_feed), 32'h0000_0001);
         check(bus_addr, 32'h1000_0000 + 32'(4 * c));
      end
      // other channel, destination data unchanged
      wr(OFS_CRC_CTRL, 32'h1000_0085, 4'hF);
      issue(3'h2, 1'b0, 32'h2000_0010, d);
      wait_done();
      check(bus_wdata, d);
      check(32'(saw_feed), 32'h0000_0000);
      rd(OFS_STATUS);
      check(v, 32'h0000_0002);
      wr(OFS_CRC_CTRL, 32'h0000_0005, 4'hF);
      issue(3'h5, 1'b0, 32'h2000_0014, d);
      wait_done();
      check(32'(saw_feed), 32'h0000_0000);
      issue(3'h6, 1'b1, 32'h3000_0020, d);
      wait_done();
      check(32'(bus_read), 32'h0000_0001);
      rd(OFS_STATUS);
      check(v, 32'h0000_000E);
      rd(OFS_LAST_ADDR);
      check(v, 32'h3000_0020);
      $display("test_access done");
   endtask : test_access

   task automatic test_suspend();
      wr(OFS_CONTROL, 32'h0000_9000, 4'hF);
      issue(3'h3, 1'b0, 32'h4000_0040, 32'h5555_AAAA);
      repeat (10) @(posedge mclk);
      check(32'(done), 32'h0000_0000);
      rd(OFS_LAST_ADDR);
      check(v, 32'h3000_0020);
      wr(OFS_CONTROL, 32'h0000_8000, 4'hF);
      wait_done();
      check(bus_addr, 32'h4000_0040);
      wr(OFS_CONTROL, 32'h0000_0000, 4'hF);
      @(posedge mclk);
      rd(OFS_CONTROL);
      check(v, 32'h0000_0000);
      check(32'(module_enable), 32'h0000_0000);
      check(32'(module_active_flag), 32'h0000_0000);
      issue(3'h4, 1'b0, 32'h5000_0050, 32'h0F0F_F0F0);
      repeat (10) @(posedge mclk);
      check(32'(done), 32'h0000_0000);
      wr(OFS_CONTROL, 32'h0000_8000, 4'hF);
      wait_done();
      check(bus_addr, 32'h5000_0050);
      $display("test_suspend done");
   endtask : test_suspend

   task automatic test_unaligned();
      wr(OFS_CRC_CTRL, 32'h0800_0000, 4'hF);
      issue(3'h1, 1'b0, 32'h6000_0102, 32'h1234_5678);
      wait_done();
      check(32'(was_refused), 32'h0000_0001);
      rd(OFS_LAST_ADDR);
      check(v, 32'h5000_0050);
      wr(OFS_CRC_CTRL, 32'h0000_0000, 4'hF);
      issue(3'h1, 1'b0, 32'h6000_0102, 32'h1234_5678);
      wait_done();
      check(32'(was_refused), 32'h0000_0000);
      check(bus_addr, 32'h6000_0102);
      $display("test_unaligned done");
   endtask : test_unaligned

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      reset_n = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, start, cmd_read} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, cmd_addr, cmd_data, cmd_channel} = '0;
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      test_reset();
      test_regs();
      test_access();
      test_suspend();
      test_unaligned();
      give_verdict();
   end
endmodule : dma_global_ctrl_crc_order_tb_top
